// [verilog/rotor_fault_map.vh]
// constants, register map and field layout of the rotor earth fault stages
// Function
// - fault voltage is poles sum plus asymmetry
// - excitation voltage is positive minus negative
// - positive voltage is resistance times current
// - negative voltage is resistance times current
// - internal module resistance added automatically
// - coupling resistances 5000..50000 ohm, default 17000
// - asymmetry factor -10.0..10.0 percent, default 0
// - warning start at threshold, default 5.0 V
// - trip start at threshold, default 7.0 V
// - overvoltage start at threshold, default 200 V
// - warning delay 1000..64000 ms, timeout output
// - trip delay 1000..64000 ms, timeout output
// - overvoltage delay 1000..64000 ms, timeout output
// - blocking input suppresses all six stage outputs
// - publish pole, differential, excitation voltages
// - six outputs, start and timeout per stage
// - timers start at detection, 20 ms tolerance
`ifndef ROTOR_FAULT_MAP_VH
`define ROTOR_FAULT_MAP_VH

// register word indices (address port is a word index)
`define REG_CTRL 4'h0
`define REG_R_POS 4'h1
`define REG_R_NEG 4'h2
`define REG_ASYM 4'h3
`define REG_WARN_THR 4'h4
`define REG_WARN_DLY 4'h5
`define REG_TRIP_THR 4'h6
`define REG_TRIP_DLY 4'h7
`define REG_OV_THR 4'h8
`define REG_OV_DLY 4'h9
`define REG_STATUS 4'ha
`define REG_IRQ_STAT 4'hb
`define REG_IRQ_MASK 4'hc
`define REG_MEAS_POS 4'hd
`define REG_MEAS_NEG 4'he
`define REG_MEAS_DIFF 4'hf

// control fields
`define CTRL_ENABLE_BIT 0

// reset values; voltages in 0.1 V units, asymmetry in 0.1 percent
`define RST_R_POS 16'h4268
`define RST_R_NEG 16'h4268
`define RST_ASYM 8'h00
`define RST_WARN_THR 16'h0032
`define RST_TRIP_THR 16'h0046
`define RST_OV_THR 16'h07d0
`define RST_DLY_MS 16'h07d0

// setting ranges
`define R_MIN 16'h1388
`define R_MAX 16'hc350
`define ASYM_MIN (-8'sd100)
`define ASYM_MAX 8'sd100
`define DU_THR_MIN 16'h0001
`define DU_THR_MAX 16'h01f4
`define OV_THR_MIN 16'h01f4
`define OV_THR_MAX 16'h2710
`define DLY_MIN 16'h03e8
`define DLY_MAX 16'hfa00

// internal module resistance in ohm
`define R_INTERNAL 16'h03e8

// timing
`define CLK_HZ 100000000
`define MS_PER_S 1000

// scale: current in microamps, ohm*uA = uV; uV per 0.1 V
`define UV_PER_DV 100000
// asymmetry factor scale: 0.1 percent units per unity
`define ASYM_SCALE 1000

`endif

// [verilog/rotor_fault_stages.v]
// rotor earth fault evaluation: voltages, three timed stages, register port
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "rotor_fault_map.vh"

module rotor_fault_stages #(
    parameter CLK_PER_MS = `CLK_HZ / `MS_PER_S,
    parameter CUR_W = 24
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // register port
    input wire [3:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    // current samples from the front end
    input wire sample_valid,
    input wire signed [CUR_W-1:0] pos_current,
    input wire signed [CUR_W-1:0] neg_current,
    // suppression input
    input wire block,
    // stage starts and timeouts
    output reg warning_stage_pickup,
    output reg trip_stage_pickup,
    output reg overvoltage_stage_pickup,
    output reg warning_stage_timeout,
    output reg trip_stage_timeout,
    output reg overvoltage_stage_timeout,
    // published voltages, 0.1 V units
    output reg signed [31:0] positive_pole_voltage_meas,
    output reg signed [31:0] negative_pole_voltage_meas,
    output reg signed [31:0] differential_fault_voltage,
    output reg signed [31:0] excitation_voltage,
    // interrupt line
    output reg irq
);

    localparam [31:0] MS_CYC = CLK_PER_MS;

    // function enable
    reg enable;

    // coupling resistances and asymmetry
    reg [15:0] r_pos;
    reg [15:0] r_neg;
    reg signed [7:0] asym;

    // stage thresholds and delays
    reg [15:0] warn_thr;
    reg [15:0] warn_dly;
    reg [15:0] trip_thr;
    reg [15:0] trip_dly;
    reg [15:0] ov_thr;
    reg [15:0] ov_dly;

    // interrupt status and mask
    reg [5:0] irq_stat;
    reg [5:0] irq_mask;

    // clamp a written value into its range
    function [15:0] clamp16;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            if (v < lo)
                clamp16 = lo;
            else if (v > hi)
                clamp16 = hi;
            else
                clamp16 = v;
        end
    endfunction

    // clamp a signed byte into its range
    function signed [7:0] clamp8s;
        input signed [7:0] v;
        input signed [7:0] lo;
        input signed [7:0] hi;
        begin
            if (v < lo)
                clamp8s = lo;
            else if (v > hi)
                clamp8s = hi;
            else
                clamp8s = v;
        end
    endfunction

    // magnitude of a signed word
    function [31:0] abs32;
        input [31:0] v;
        begin
            if (v[31])
                abs32 = 32'h00000000 - v;
            else
                abs32 = v;
        end
    endfunction

    // threshold compare against a 16-bit setting
    function stage_hit;
        input [31:0] mag;
        input [15:0] thr;
        begin
            stage_hit = (mag >= {16'h0000, thr});
        end
    endfunction

    // zero-extend a setting for the read port
    function [31:0] zext16;
        input [15:0] v;
        begin
            zext16 = {16'h0000, v};
        end
    endfunction

    // register writes
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enable <= 1'b0;
            r_pos <= `RST_R_POS;
            r_neg <= `RST_R_NEG;
            asym <= `RST_ASYM;
            warn_thr <= `RST_WARN_THR;
            trip_thr <= `RST_TRIP_THR;
            ov_thr <= `RST_OV_THR;
            warn_dly <= `RST_DLY_MS;
            trip_dly <= `RST_DLY_MS;
            ov_dly <= `RST_DLY_MS;
            irq_mask <= 6'h00;
        end else if (wr) begin
            case (addr)
                `REG_CTRL: begin
                    enable <= wdata[`CTRL_ENABLE_BIT];
                end
                `REG_R_POS: begin
                    r_pos <= clamp16(wdata[15:0], `R_MIN, `R_MAX);
                end
                `REG_R_NEG: begin
                    r_neg <= clamp16(wdata[15:0], `R_MIN, `R_MAX);
                end
                `REG_ASYM: begin
                    asym <= clamp8s(wdata[7:0], `ASYM_MIN, `ASYM_MAX);
                end
                `REG_WARN_THR: begin
                    warn_thr <= clamp16(wdata[15:0], `DU_THR_MIN, `DU_THR_MAX);
                end
                `REG_WARN_DLY: begin
                    warn_dly <= clamp16(wdata[15:0], `DLY_MIN, `DLY_MAX);
                end
                `REG_TRIP_THR: begin
                    trip_thr <= clamp16(wdata[15:0], `DU_THR_MIN, `DU_THR_MAX);
                end
                `REG_TRIP_DLY: begin
                    trip_dly <= clamp16(wdata[15:0], `DLY_MIN, `DLY_MAX);
                end
                `REG_OV_THR: begin
                    ov_thr <= clamp16(wdata[15:0], `OV_THR_MIN, `OV_THR_MAX);
                end
                `REG_OV_DLY: begin
                    ov_dly <= clamp16(wdata[15:0], `DLY_MIN, `DLY_MAX);
                end
                `REG_IRQ_MASK: begin
                    irq_mask <= wdata[5:0];
                end
                default: begin
                end
            endcase
        end
    end

    // coupling resistance plus internal module resistance
    wire [16:0] r_pos_tot;
    wire [16:0] r_neg_tot;
    assign r_pos_tot = {1'b0, r_pos} + {1'b0, `R_INTERNAL};
    assign r_neg_tot = {1'b0, r_neg} + {1'b0, `R_INTERNAL};

    // pole voltages: currents in uA give uV, then 0.1 V units
    wire signed [47:0] uv_pos;
    wire signed [47:0] uv_neg;
    wire signed [47:0] dv_pos;
    wire signed [47:0] dv_neg;
    assign uv_pos = $signed({1'b0, r_pos_tot}) * pos_current;
    assign uv_neg = $signed({1'b0, r_neg_tot}) * neg_current;
    assign dv_pos = uv_pos / $signed(48'd`UV_PER_DV);
    assign dv_neg = uv_neg / $signed(48'd`UV_PER_DV);

    // excitation, asymmetry share and fault voltage
    wire signed [47:0] dv_exc;
    wire signed [47:0] dv_asym;
    wire signed [47:0] dv_diff;
    assign dv_exc = dv_pos - dv_neg;
    assign dv_asym = (dv_exc * asym) / $signed(48'd`ASYM_SCALE);
    assign dv_diff = dv_pos + dv_neg + dv_asym;

    // published measurements, refreshed on each sample
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            positive_pole_voltage_meas <= 32'h00000000;
            negative_pole_voltage_meas <= 32'h00000000;
            excitation_voltage <= 32'h00000000;
            differential_fault_voltage <= 32'h00000000;
        end else if (sample_valid) begin
            positive_pole_voltage_meas <= dv_pos[31:0];
            negative_pole_voltage_meas <= dv_neg[31:0];
            excitation_voltage <= dv_exc[31:0];
            differential_fault_voltage <= dv_diff[31:0];
        end
    end

    // magnitudes of the compared quantities
    wire [31:0] du_mag;
    wire [31:0] ue_mag;
    wire active;
    assign du_mag = abs32(differential_fault_voltage);
    assign ue_mag = abs32(excitation_voltage);
    assign active = enable & ~block;

    // stage pickups: compare, threshold, delay
    wire [2:0] pick;
    wire [47:0] dly_ms;
    assign pick[0] = active & stage_hit(du_mag, warn_thr);
    assign pick[1] = active & stage_hit(du_mag, trip_thr);
    assign pick[2] = active & stage_hit(ue_mag, ov_thr);
    assign dly_ms = {ov_dly, trip_dly, warn_dly};

    // per-stage millisecond timers
    reg [2:0] start_q;
    reg [2:0] tmo_q;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : stage
            // cycles within the current millisecond
            reg [31:0] cyc;
            // elapsed whole milliseconds
            reg [15:0] ms;
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    cyc <= 32'h00000000;
                    ms <= 16'h0000;
                    start_q[g] <= 1'b0;
                    tmo_q[g] <= 1'b0;
                end else if (!pick[g]) begin
                    cyc <= 32'h00000000;
                    ms <= 16'h0000;
                    start_q[g] <= 1'b0;
                    tmo_q[g] <= 1'b0;
                end else begin
                    start_q[g] <= 1'b1;
                    if (ms >= dly_ms[16*g +: 16])
                        tmo_q[g] <= 1'b1;
                    else if (cyc == MS_CYC - 32'h00000001) begin
                        cyc <= 32'h00000000;
                        ms <= ms + 16'h0001;
                    end else
                        cyc <= cyc + 32'h00000001;
                end
            end
        end
    endgenerate

    // warning stage outputs straight from flops
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            warning_stage_pickup <= 1'b0;
            warning_stage_timeout <= 1'b0;
        end else begin
            warning_stage_pickup <= start_q[0] & pick[0];
            warning_stage_timeout <= tmo_q[0] & pick[0];
        end
    end

    // trip stage outputs straight from flops
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trip_stage_pickup <= 1'b0;
            trip_stage_timeout <= 1'b0;
        end else begin
            trip_stage_pickup <= start_q[1] & pick[1];
            trip_stage_timeout <= tmo_q[1] & pick[1];
        end
    end

    // overvoltage stage outputs straight from flops
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            overvoltage_stage_pickup <= 1'b0;
            overvoltage_stage_timeout <= 1'b0;
        end else begin
            overvoltage_stage_pickup <= start_q[2] & pick[2];
            overvoltage_stage_timeout <= tmo_q[2] & pick[2];
        end
    end

    // rising edges of the six outputs feed the sticky status
    reg [5:0] out_prev;
    wire [5:0] out_now;
    wire [5:0] ev;
    wire stat_rd;
    wire [5:0] next_irq_stat;
    assign out_now = {overvoltage_stage_timeout, trip_stage_timeout,
        warning_stage_timeout, overvoltage_stage_pickup, trip_stage_pickup,
        warning_stage_pickup};
    assign ev = out_now & ~out_prev;
    assign stat_rd = rd & (addr == `REG_IRQ_STAT);

    // status after this cycle: a read clears, a new event still sets
    assign next_irq_stat = (stat_rd ? 6'h00 : irq_stat) | ev;

    // sticky status, read clears, set wins
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_prev <= 6'h00;
            irq_stat <= 6'h00;
            irq <= 1'b0;
        end else begin
            out_prev <= out_now;
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_mask);
        end
    end

    // read data, valid in the cycle after the strobe
    always @(posedge clk_sys or posedge rst) begin
        if (rst)
            rdata <= 32'h00000000;
        else if (rd) begin
            case (addr)
                `REG_CTRL:
                    rdata <= {31'h00000000, enable};
                `REG_R_POS:
                    rdata <= zext16(r_pos);
                `REG_R_NEG:
                    rdata <= zext16(r_neg);
                `REG_ASYM:
                    rdata <= {{24{asym[7]}}, asym};
                `REG_WARN_THR:
                    rdata <= zext16(warn_thr);
                `REG_WARN_DLY:
                    rdata <= zext16(warn_dly);
                `REG_TRIP_THR:
                    rdata <= zext16(trip_thr);
                `REG_TRIP_DLY:
                    rdata <= zext16(trip_dly);
                `REG_OV_THR:
                    rdata <= zext16(ov_thr);
                `REG_OV_DLY:
                    rdata <= zext16(ov_dly);
                `REG_STATUS:
                    rdata <= {26'h0000000, out_now};
                `REG_IRQ_STAT:
                    rdata <= {26'h0000000, irq_stat};
                `REG_IRQ_MASK:
                    rdata <= {26'h0000000, irq_mask};
                `REG_MEAS_POS:
                    rdata <= positive_pole_voltage_meas;
                `REG_MEAS_NEG:
                    rdata <= negative_pole_voltage_meas;
                `REG_MEAS_DIFF:
                    rdata <= differential_fault_voltage;
                default:
                    rdata <= 32'h00000000;
            endcase
        end else
            rdata <= 32'h00000000;
    end

endmodule // rotor_fault_stages

// [verification/acq_front_end.sv]
// acquisition front end model: periodic current sample pairs
`timescale 1ns/1ps
module acq_front_end #(
    parameter PERIOD = 8
) (
    input wire clk_sys,
    input wire rst,
    input wire signed [23:0] pos_set,
    input wire signed [23:0] neg_set,
    output reg sample_valid,
    output reg signed [23:0] pos_current,
    output reg signed [23:0] neg_current
);
reg [7:0] cnt;
wire last = (cnt == PERIOD - 1);
// one sample pulse a period; current lines toggle between samples
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        cnt <= 8'h00;
        sample_valid <= 1'b0;
        pos_current <= 24'h000000;
        neg_current <= 24'h000000;
    end else begin
        cnt <= last ? 8'h00 : cnt + 8'h01;
        sample_valid <= last;
        pos_current <= last ? pos_set : ~pos_current;
        neg_current <= last ? neg_set : ~neg_current;
    end
end
endmodule // acq_front_end

// [verification/fault_stage_chk.sv]
// port assertions for the rotor fault stages
`timescale 1ns/1ps
module fault_stage_chk #(
    parameter CLK_PER_MS = 10,
    parameter CUR_W = 24
) (
    input wire clk_sys,
    input wire rst,
    input wire [3:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    input wire sample_valid,
    input wire signed [CUR_W-1:0] pos_current,
    input wire signed [CUR_W-1:0] neg_current,
    input wire block,
    input wire warning_stage_pickup,
    input wire trip_stage_pickup,
    input wire overvoltage_stage_pickup,
    input wire warning_stage_timeout,
    input wire trip_stage_timeout,
    input wire overvoltage_stage_timeout,
    input wire signed [31:0] positive_pole_voltage_meas,
    input wire signed [31:0] negative_pole_voltage_meas,
    input wire signed [31:0] differential_fault_voltage,
    input wire signed [31:0] excitation_voltage,
    input wire irq
);
wire [5:0] outs = {overvoltage_stage_timeout, trip_stage_timeout, warning_stage_timeout,
    overvoltage_stage_pickup, trip_stage_pickup, warning_stage_pickup};
default clocking cb @(posedge clk_sys); endclocking
default disable iff (rst);
rdata_idle_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not idle");
meas_hold_a: assert property (!sample_valid |=> $stable(positive_pole_voltage_meas)
    && $stable(negative_pole_voltage_meas) && $stable(differential_fault_voltage)
    && $stable(excitation_voltage)) else $error("measurement moved without sample");
block_quiet_a: assert property (block[*4] |-> outs == 6'h00)
    else $error("stage output while blocked");
warn_tmo_start_a: assert property ($rose(warning_stage_timeout) |-> warning_stage_pickup)
    else $error("warning timeout without start");
trip_tmo_start_a: assert property ($rose(trip_stage_timeout) |-> trip_stage_pickup)
    else $error("trip timeout without start");
ov_tmo_start_a: assert property ($rose(overvoltage_stage_timeout)
    |-> overvoltage_stage_pickup) else $error("overvoltage timeout without start");
tmo_not_early_a: assert property ($rose(warning_stage_pickup)
    |-> !warning_stage_timeout [*8]) else $error("timeout right after start");
trip_drop_a: assert property ($fell(trip_stage_pickup) |-> !trip_stage_timeout)
    else $error("trip timeout outlived start");
endmodule // fault_stage_chk
bind rotor_fault_stages fault_stage_chk #(.CLK_PER_MS(CLK_PER_MS), .CUR_W(CUR_W)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sample_valid(sample_valid), .pos_current(pos_current),
    .neg_current(neg_current), .block(block), .warning_stage_pickup(warning_stage_pickup),
    .trip_stage_pickup(trip_stage_pickup), .overvoltage_stage_pickup(overvoltage_stage_pickup),
    .warning_stage_timeout(warning_stage_timeout), .trip_stage_timeout(trip_stage_timeout),
    .overvoltage_stage_timeout(overvoltage_stage_timeout),
    .positive_pole_voltage_meas(positive_pole_voltage_meas),
    .negative_pole_voltage_meas(negative_pole_voltage_meas),
    .differential_fault_voltage(differential_fault_voltage),
    .excitation_voltage(excitation_voltage), .irq(irq));

// [verification/rotor_fault_stages_test.sv]
// self-checking bench for the rotor fault stages
`timescale 1ns/1ps
`include "rotor_fault_map.vh"
module rotor_fault_stages_test;
reg clk_sys, rst, wr, rd, block;
reg [3:0] addr;
reg [31:0] wdata;
reg signed [23:0] pos_set, neg_set;
wire sample_valid, wp, tp, op, wt, tt, ot, irq;
wire signed [23:0] pos_current, neg_current;
wire [31:0] rdata;
wire signed [31:0] vp, vn, vd, ve;
wire [5:0] flags = {ot, tt, wt, op, tp, wp};
integer n_errors, checked, i;
reg [31:0] dflt [1:9];
rotor_fault_stages #(.CLK_PER_MS(10), .CUR_W(24)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sample_valid(sample_valid),
    .pos_current(pos_current), .neg_current(neg_current), .block(block),
    .warning_stage_pickup(wp), .trip_stage_pickup(tp), .overvoltage_stage_pickup(op),
    .warning_stage_timeout(wt), .trip_stage_timeout(tt), .overvoltage_stage_timeout(ot),
    .positive_pole_voltage_meas(vp), .negative_pole_voltage_meas(vn),
    .differential_fault_voltage(vd), .excitation_voltage(ve), .irq(irq));
acq_front_end #(.PERIOD(8)) u_fe (.clk_sys(clk_sys), .rst(rst), .pos_set(pos_set),
    .neg_set(neg_set), .sample_valid(sample_valid), .pos_current(pos_current),
    .neg_current(neg_current));
task chk(input [31:0] got, input [31:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
endtask
task chk_flags(input [5:0] exp);
    begin
        #1;
        chk({26'h0, flags}, {26'h0, exp});
    end
endtask
task cyc(input integer n);
    repeat (n) @(posedge clk_sys);
endtask
task wr_reg(input [3:0] a, input [31:0] d);
    begin
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    end
endtask
task rd_chk(input [3:0] a, input [31:0] exp);
    begin
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    end
endtask
// new current pair, then let a sample and the pickup path settle
task cur(input signed [23:0] p, input signed [23:0] n);
    begin
        @(posedge clk_sys);
        pos_set <= p;
        neg_set <= n;
        cyc(20);
    end
endtask
task give_verdict;
    begin
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
endtask
// 100 MHz clock
initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
end
// hang guard
initial begin
    cyc(60000);
    n_errors = n_errors + 1;
    give_verdict;
end
// main sequence
initial begin
    {rst, wr, rd, block, addr, wdata} = {4'h8, 4'h0, 32'h0};
    {pos_set, neg_set, n_errors, checked} = 0;
    dflt[1] = `RST_R_POS; dflt[2] = `RST_R_NEG; dflt[3] = {24'h0, `RST_ASYM};
    dflt[4] = `RST_WARN_THR; dflt[6] = `RST_TRIP_THR; dflt[8] = `RST_OV_THR;
    dflt[5] = `RST_DLY_MS; dflt[7] = `RST_DLY_MS; dflt[9] = `RST_DLY_MS;
    cyc(10);
    rst <= 1'b0;
    rd_chk(`REG_CTRL, 32'h0);
    for (i = 1; i < 10; i = i + 1) rd_chk(i[3:0], dflt[i]);
    wr_reg(`REG_R_POS, 32'h0bb8);
    rd_chk(`REG_R_POS, `R_MIN);
    wr_reg(`REG_R_POS, 32'hea60);
    rd_chk(`REG_R_POS, `R_MAX);
    wr_reg(`REG_R_POS, 32'h4a38);
    wr_reg(`REG_R_NEG, 32'h4a38);
    for (i = 5; i < 10; i = i + 2) wr_reg(i[3:0], 32'h03e8);
    wr_reg(`REG_ASYM, 32'h0a);
    cur(24'sh001388, -24'sh001388);
    chk(vp, 32'h3e8);
    chk(vn, 32'hfffffc18);
    chk(ve, 32'h7d0);
    chk(vd, 32'h14);
    chk_flags(6'h00);
    wr_reg(`REG_ASYM, 32'h0);
    cur(24'sh001388, -24'sh00128e);
    chk(vn, 32'hfffffc4a);
    chk(vd, 32'h32);
    wr_reg(`REG_CTRL, 32'h1);
    i = 0;
    while (wp !== 1'b1 && i < 40) begin
        @(posedge clk_sys);
        i = i + 1;
    end
    chk_flags(6'h01);
    chk({31'h0, irq}, 32'h0);
    cyc(9990);
    chk_flags(6'h01);
    cyc(20);
    chk_flags(6'h09);
    cur(24'sh00157c, -24'sh001388);
    chk_flags(6'h0f);
    rd_chk(`REG_MEAS_DIFF, 32'h64);
    cyc(10010);
    chk_flags(6'h3f);
    wr_reg(`REG_IRQ_MASK, 32'h3f);
    cyc(3);
    #1 chk({31'h0, irq}, 32'h1);
    rd_chk(`REG_IRQ_STAT, 32'h3f);
    rd_chk(`REG_STATUS, 32'h3f);
    cyc(3);
    #1 chk({31'h0, irq}, 32'h0);
    rd_chk(`REG_IRQ_STAT, 32'h0);
    @(posedge clk_sys) block <= 1'b1;
    cyc(6);
    chk_flags(6'h00);
    @(posedge clk_sys) block <= 1'b0;
    cyc(20);
    chk_flags(6'h07);
    cur(24'sh001388, -24'sh001388);
    chk_flags(6'h04);
    wr_reg(`REG_CTRL, 32'h0);
    cyc(6);
    chk_flags(6'h00);
    give_verdict;
end
endmodule // rotor_fault_stages_test
